// [shared/fsce_pkg.sv]
package fsce_pkg;
	// status word layout
	localparam int SW_BUSY = 15;
	localparam int SW_TOP_LSB = 12;
	localparam int SW_CC_LSB = 8;
	localparam int SW_ES = 7;
	localparam logic [15:0] SW_RST = 16'h0000;
	// control word layout
	localparam int CW_PC_LSB = 8;
	localparam int CW_RC_LSB = 10;
	localparam int CW_IC = 12;
	localparam logic [15:0] CW_RST = 16'h033F;
	localparam logic [15:0] CW_USED = 16'h1F3F;
	// exception flag and mask positions
	localparam int EXC_INV = 0;
	localparam int EXC_DEN = 1;
	localparam int EXC_ZDV = 2;
	localparam int EXC_OVF = 3;
	localparam int EXC_UNF = 4;
	localparam int EXC_PRE = 5;
	// pointer image widths
	localparam int REAL_ADDR_W = 20;
	localparam int OPC_W = 11;
	// environment word indices
	localparam logic [2:0] ENV_CTRL = 3'h0;
	localparam logic [2:0] ENV_STAT = 3'h1;
	localparam logic [2:0] ENV_IP_LO = 3'h2;
	localparam logic [2:0] ENV_IP_HI = 3'h3;
	localparam logic [2:0] ENV_OP_LO = 3'h4;
	localparam logic [2:0] ENV_OP_HI = 3'h5;
	// host commands decoded by the bus interface unit
	typedef enum logic [3:0] {
		FSCE_CMD_NOP = 4'h0,
		FSCE_CMD_STORE_STATUS = 4'h1,
		FSCE_CMD_STORE_CTRL = 4'h2,
		FSCE_CMD_STORE_ENV = 4'h3,
		FSCE_CMD_SAVE_STATE = 4'h4,
		FSCE_CMD_LOAD_CTRL = 4'h5,
		FSCE_CMD_LOAD_ENV = 4'h6,
		FSCE_CMD_RESTORE_STATE = 4'h7,
		FSCE_CMD_CLEAR_EXC = 4'h8,
		FSCE_CMD_INIT = 4'h9,
		FSCE_CMD_ESC_EXEC = 4'hA
	} fsce_cmd_t;
	// condition code update kinds
	typedef enum logic [2:0] {
		FSCE_CC_NONE = 3'h0,
		FSCE_CC_COMPARE = 3'h1,
		FSCE_CC_REMAINDER = 3'h2,
		FSCE_CC_EXAMINE = 3'h3,
		FSCE_CC_ARITH = 3'h4
	} fsce_cc_kind_t;
	// compare outcome
	typedef enum logic [1:0] {
		FSCE_CMP_GT = 2'h0,
		FSCE_CMP_LT = 2'h1,
		FSCE_CMP_EQ = 2'h2,
		FSCE_CMP_UNORD = 2'h3
	} fsce_cmp_t;
	// stack operation
	typedef enum logic [1:0] {
		FSCE_STK_NONE = 2'h0,
		FSCE_STK_PUSH = 2'h1,
		FSCE_STK_POP = 2'h2
	} fsce_stk_t;
	// execution unit state, gray along idle -> busy
	typedef enum logic {
		FSCE_EU_IDLE = 1'b0,
		FSCE_EU_BUSY = 1'b1
	} fsce_eu_t;
endpackage

// [verilog/fsce_cc_encode.sv]
`timescale 1ns/1ps
// condition code encoder for compare, remainder, examine and plain arithmetic
module fsce_cc_encode (
	input wire logic [2:0] i_kind,
	input wire logic [1:0] i_cmp,
	input wire logic i_rem_complete,
	input wire logic [2:0] i_rem_quot,
	input wire logic [3:0] i_cc_value,
	input wire logic i_sign,
	input wire logic [14:0] i_exp,
	input wire logic [63:0] i_sig,
	input wire logic i_empty,
	output logic [3:0] o_cc,
	output logic [3:0] o_cc_we,
	output logic o_is_nan
);
	logic exp_ones;
	logic exp_zero;
	logic frac_zero;
	assign exp_ones = &i_exp;
	assign exp_zero = ~|i_exp;
	assign frac_zero = ~|i_sig[62:0];
	// all-ones exponent with nonzero fraction bits 62 to 0 marks a nan
	assign o_is_nan = exp_ones & ~frac_zero;

	// codes are {c3,c2,c1,c0}
	always_comb begin
		o_cc = 4'h0;
		o_cc_we = 4'h0;
		case (fsce_pkg::fsce_cc_kind_t'(i_kind))
			fsce_pkg::FSCE_CC_COMPARE: begin
				o_cc_we = 4'hD;
				case (fsce_pkg::fsce_cmp_t'(i_cmp))
					fsce_pkg::FSCE_CMP_GT: o_cc = 4'h0;
					fsce_pkg::FSCE_CMP_LT: o_cc = 4'h1;
					fsce_pkg::FSCE_CMP_EQ: o_cc = 4'h8;
					default: o_cc = 4'hD;
				endcase
			end
			fsce_pkg::FSCE_CC_REMAINDER: begin
				if (i_rem_complete) begin
					o_cc = {i_rem_quot[1], 1'b0, i_rem_quot[0], i_rem_quot[2]};
					o_cc_we = 4'hF;
				end else begin
					// other flags undefined; kept as they were
					o_cc = 4'h4;
					o_cc_we = 4'h4;
				end
			end
			fsce_pkg::FSCE_CC_EXAMINE: begin
				o_cc_we = 4'hF;
				if (i_empty) begin
					o_cc = {3'h4, 1'b1};
				end else if (exp_zero && i_sig == 64'h0) begin
					o_cc = {2'h2, i_sign, 1'b0};
				end else if (exp_ones && frac_zero) begin
					o_cc = {2'h1, i_sign, 1'b1};
				end else if (exp_ones) begin
					// nan gets its own class, c0 set with c3 c2 clear, apart from the all-zero unsupported class
					o_cc = {2'h0, i_sign, 1'b1};
				end else if (exp_zero) begin
					o_cc = {2'h3, i_sign, 1'b0};
				end else if (i_sig[63]) begin
					o_cc = {2'h1, i_sign, 1'b0};
				end else begin
					o_cc = {2'h0, i_sign, 1'b0};
				end
			end
			fsce_pkg::FSCE_CC_ARITH: begin
				o_cc = i_cc_value;
				o_cc_we = 4'hF;
			end
			default: begin
				o_cc = 4'h0;
				o_cc_we = 4'h0;
			end
		endcase
	end
endmodule // fsce_cc_encode

// [verilog/fsce_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - status bit 15 reads 1 while the execution unit works, 0 when idle.
// - status and environment stores never set busy nor wait for it.
// - four condition flags in status follow arithmetic-type instruction outcomes.
// - status bits 14 to 12 hold the top-of-stack register index.
// - bit 7 set when an unmasked flag is set; it drives the error output.
// - status bits 5 to 0 are sticky exception flags set on detection.
// - implicit operands use top; explicit numbers count relative to top.
// - a new instruction captures instruction address, operand address and opcode.
// - real mode keeps 20-bit addresses and 11-bit opcode; protected keeps 32 bits.
// - captured instruction address points at the first prefix byte.
// - protected mode leaves the opcode out of the pointer image.
// - control bits 5 to 0 mask exceptions and select default responses.
// - control bits 9 and 8 choose reduced precision below full extended.
// - control bits 11 and 10 choose the rounding mode.
// - a control bit selects affine or projective infinity closure.
// - compare and test set c3 c2 c0 by outcome; c1 is kept.
// - complete remainder gives quotient bits; incomplete sets c2 only.
// - examine encodes the class and sign of the top register.
// - invalid covers stack faults and nans; masked gives default or propagated nan.
// - overflow and zero divide give a signed infinity when masked.
// - masked underflow denormalises the result by right shifting.
// - inexact results round per control and set the inexact flag.
// - push decrements top then writes; pop reads then increments top.
// - busy output rises as soon as execution begins.
module fsce_top (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd_code,
	input wire logic [2:0] i_cmd_word,
	input wire logic [15:0] i_cmd_data,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data,
	input wire logic i_exec_start,
	input wire logic i_exec_done,
	input wire logic [31:0] i_esc_addr,
	input wire logic [3:0] i_prefix_len,
	input wire logic i_oper_valid,
	input wire logic [31:0] i_oper_addr,
	input wire logic [10:0] i_opcode,
	input wire logic i_prot_mode,
	input wire logic [1:0] i_stack_op,
	input wire logic [2:0] i_reg_rel,
	input wire logic [5:0] i_exc_detect,
	input wire logic i_res_sign,
	input wire logic [2:0] i_cc_kind,
	input wire logic [1:0] i_cmp_result,
	input wire logic i_rem_complete,
	input wire logic [2:0] i_rem_quot,
	input wire logic [3:0] i_cc_value,
	input wire logic i_opnd_sign,
	input wire logic [14:0] i_opnd_exp,
	input wire logic [63:0] i_opnd_sig,
	input wire logic i_opnd_empty,
	output logic [2:0] o_reg_index,
	output logic o_busy,
	output logic o_error,
	output logic [15:0] o_status,
	output logic [15:0] o_control,
	output logic [31:0] o_instr_ptr,
	output logic [31:0] o_oper_ptr,
	output logic [10:0] o_opcode,
	output logic o_resp_nan_default,
	output logic o_resp_nan_prop,
	output logic o_resp_infinity,
	output logic o_resp_inf_sign,
	output logic o_resp_denorm,
	output logic o_resp_continue,
	output logic o_exc_fault
);
	fsce_pkg::fsce_cmd_t cmd;
	fsce_pkg::fsce_eu_t eu_r;
	fsce_pkg::fsce_eu_t eu_nxt;
	logic [2:0] top_r;
	logic [2:0] top_nxt;
	logic [3:0] cc_r;
	logic [3:0] cc_nxt;
	logic [5:0] flags_r;
	logic [5:0] flags_nxt;
	logic [15:0] ctrl_r;
	logic [15:0] ctrl_nxt;
	logic es_nxt;
	logic ld_ctrl;
	logic ld_stat;
	logic do_init;
	logic rd_req;
	logic [15:0] rd_nxt;
	logic [3:0] enc_cc;
	logic [3:0] enc_we;
	logic opnd_nan;
	logic [31:0] first_byte;
	logic prot_r;
	logic [31:0] ip_r;
	logic [31:0] op_r;
	logic [10:0] opc_r;
	logic [5:0] mask_now;
	logic [5:0] det_masked;

	assign cmd = fsce_pkg::fsce_cmd_t'(i_cmd_code);
	assign mask_now = ctrl_r[5:0];
	assign det_masked = i_exc_detect & mask_now;

	// command decode: control loads, status loads and reads
	always_comb begin
		ld_ctrl = 1'b0;
		ld_stat = 1'b0;
		do_init = 1'b0;
		rd_req = 1'b0;
		if (i_cmd_valid) begin
			case (cmd)
				fsce_pkg::FSCE_CMD_LOAD_CTRL: ld_ctrl = 1'b1;
				fsce_pkg::FSCE_CMD_LOAD_ENV,
				fsce_pkg::FSCE_CMD_RESTORE_STATE: begin
					ld_ctrl = (i_cmd_word == fsce_pkg::ENV_CTRL);
					ld_stat = (i_cmd_word == fsce_pkg::ENV_STAT);
				end
				fsce_pkg::FSCE_CMD_INIT: do_init = 1'b1;
				fsce_pkg::FSCE_CMD_STORE_STATUS,
				fsce_pkg::FSCE_CMD_STORE_CTRL,
				fsce_pkg::FSCE_CMD_STORE_ENV,
				fsce_pkg::FSCE_CMD_SAVE_STATE: rd_req = 1'b1;
				default: rd_req = 1'b0;
			endcase
		end
	end

	// condition code classification lives in its own leaf
	fsce_cc_encode u_cc (
		.i_kind(i_cc_kind),
		.i_cmp(i_cmp_result),
		.i_rem_complete(i_rem_complete),
		.i_rem_quot(i_rem_quot),
		.i_cc_value(i_cc_value),
		.i_sign(i_opnd_sign),
		.i_exp(i_opnd_exp),
		.i_sig(i_opnd_sig),
		.i_empty(i_opnd_empty),
		.o_cc(enc_cc),
		.o_cc_we(enc_we),
		.o_is_nan(opnd_nan)
	);

	// busy follows the execution unit; init is the only admin command that touches it
	always_comb begin
		eu_nxt = eu_r;
		case (eu_r)
			fsce_pkg::FSCE_EU_IDLE: begin
				if (i_exec_start) begin
					eu_nxt = fsce_pkg::FSCE_EU_BUSY;
				end
			end
			fsce_pkg::FSCE_EU_BUSY: begin
				// a back-to-back start keeps busy high
				if (i_exec_done && !i_exec_start) begin
					eu_nxt = fsce_pkg::FSCE_EU_IDLE;
				end
			end
			default: eu_nxt = fsce_pkg::FSCE_EU_IDLE;
		endcase
		if (do_init) begin
			eu_nxt = fsce_pkg::FSCE_EU_IDLE;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			eu_r <= fsce_pkg::FSCE_EU_IDLE;
			o_busy <= 1'b0;
		end else begin
			eu_r <= eu_nxt;
			o_busy <= (eu_nxt == fsce_pkg::FSCE_EU_BUSY);
		end
	end

	// top pointer: wraps naturally in three bits
	always_comb begin
		top_nxt = top_r;
		case (fsce_pkg::fsce_stk_t'(i_stack_op))
			fsce_pkg::FSCE_STK_PUSH: top_nxt = top_r - 3'h1;
			fsce_pkg::FSCE_STK_POP: top_nxt = top_r + 3'h1;
			default: top_nxt = top_r;
		endcase
		if (ld_stat) begin
			top_nxt = i_cmd_data[fsce_pkg::SW_TOP_LSB +: 3];
		end
		if (do_init) begin
			top_nxt = 3'h0;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			top_r <= 3'h0;
		end else begin
			top_r <= top_nxt;
		end
	end

	// physical register select; push writes the new top, pop reads the old
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_index <= 3'h0;
		end else if (i_stack_op == 2'(fsce_pkg::FSCE_STK_PUSH)) begin
			o_reg_index <= top_r - 3'h1;
		end else if (i_stack_op == 2'(fsce_pkg::FSCE_STK_POP)) begin
			o_reg_index <= top_r;
		end else begin
			o_reg_index <= top_r + i_reg_rel;
		end
	end

	// condition codes: per-bit write enable keeps untouched bits
	always_comb begin
		cc_nxt = (cc_r & ~enc_we) | (enc_cc & enc_we);
		if (ld_stat) begin
			cc_nxt = i_cmd_data[fsce_pkg::SW_CC_LSB +: 4];
		end
		if (do_init) begin
			cc_nxt = 4'h0;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cc_r <= 4'h0;
		end else begin
			cc_r <= cc_nxt;
		end
	end

	// sticky flags; a detection in the clearing cycle survives
	always_comb begin
		flags_nxt = flags_r;
		if (i_cmd_valid && cmd == fsce_pkg::FSCE_CMD_CLEAR_EXC) begin
			flags_nxt = 6'h00;
		end
		if (ld_stat) begin
			flags_nxt = i_cmd_data[5:0];
		end
		if (do_init) begin
			flags_nxt = 6'h00;
		end
		flags_nxt = flags_nxt | i_exc_detect;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			flags_r <= 6'h00;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// control word; unused bits hold zero
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ld_ctrl) begin
			ctrl_nxt = i_cmd_data & fsce_pkg::CW_USED;
		end
		if (do_init) begin
			ctrl_nxt = fsce_pkg::CW_RST;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_r <= fsce_pkg::CW_RST;
			o_control <= fsce_pkg::CW_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			o_control <= ctrl_nxt;
		end
	end

	// summary from next values, so loads and clears show at once
	assign es_nxt = |(flags_nxt & ~ctrl_nxt[5:0]);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_error <= 1'b0;
			o_status <= fsce_pkg::SW_RST;
		end else begin
			o_error <= es_nxt;
			o_status <= {eu_nxt == fsce_pkg::FSCE_EU_BUSY, top_nxt, cc_nxt,
				es_nxt, 1'b0, flags_nxt};
		end
	end

	// prefix-adjusted start of the instruction
	assign first_byte = i_esc_addr - {28'h0000000, i_prefix_len};

	// pointer capture on each new numeric instruction
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prot_r <= 1'b0;
			ip_r <= 32'h00000000;
			op_r <= 32'h00000000;
			opc_r <= 11'h000;
		end else if (i_cmd_valid && cmd == fsce_pkg::FSCE_CMD_ESC_EXEC) begin
			prot_r <= i_prot_mode;
			if (i_prot_mode) begin
				ip_r <= first_byte;
				opc_r <= 11'h000;
				if (i_oper_valid) begin
					op_r <= i_oper_addr;
				end
			end else begin
				ip_r <= {12'h000, first_byte[fsce_pkg::REAL_ADDR_W-1:0]};
				opc_r <= i_opcode;
				if (i_oper_valid) begin
					op_r <= {12'h000, i_oper_addr[fsce_pkg::REAL_ADDR_W-1:0]};
				end
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_instr_ptr <= 32'h00000000;
			o_oper_ptr <= 32'h00000000;
			o_opcode <= 11'h000;
		end else begin
			o_instr_ptr <= ip_r;
			o_oper_ptr <= op_r;
			o_opcode <= opc_r;
		end
	end

	// read word mux; real mode packs opcode beside the high address nibble
	always_comb begin
		rd_nxt = 16'h0000;
		case (cmd)
			fsce_pkg::FSCE_CMD_STORE_STATUS: begin
				rd_nxt = {eu_r == fsce_pkg::FSCE_EU_BUSY, top_r, cc_r,
					|(flags_r & ~ctrl_r[5:0]), 1'b0, flags_r};
			end
			fsce_pkg::FSCE_CMD_STORE_CTRL: rd_nxt = ctrl_r;
			default: begin
				case (i_cmd_word)
					fsce_pkg::ENV_CTRL: rd_nxt = ctrl_r;
					fsce_pkg::ENV_STAT: begin
						rd_nxt = {eu_r == fsce_pkg::FSCE_EU_BUSY, top_r, cc_r,
							|(flags_r & ~ctrl_r[5:0]), 1'b0, flags_r};
					end
					fsce_pkg::ENV_IP_LO: rd_nxt = ip_r[15:0];
					fsce_pkg::ENV_IP_HI: begin
						// opcode only travels in the real mode image
						rd_nxt = prot_r ? ip_r[31:16] :
							{ip_r[19:16], 1'b0, opc_r};
					end
					fsce_pkg::ENV_OP_LO: rd_nxt = op_r[15:0];
					fsce_pkg::ENV_OP_HI: begin
						rd_nxt = prot_r ? op_r[31:16] : {op_r[19:16], 12'h000};
					end
					default: rd_nxt = 16'h0000;
				endcase
			end
		endcase
	end

	// stores answer the next cycle regardless of busy
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rd_valid <= 1'b0;
			o_rd_data <= 16'h0000;
		end else begin
			o_rd_valid <= rd_req;
			if (rd_req) begin
				o_rd_data <= rd_nxt;
			end
		end
	end

	// masked default responses; an unmasked one faults instead
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_resp_nan_default <= 1'b0;
			o_resp_nan_prop <= 1'b0;
			o_resp_infinity <= 1'b0;
			o_resp_inf_sign <= 1'b0;
			o_resp_denorm <= 1'b0;
			o_resp_continue <= 1'b0;
			o_exc_fault <= 1'b0;
		end else begin
			o_resp_nan_default <= det_masked[fsce_pkg::EXC_INV] & ~opnd_nan;
			o_resp_nan_prop <= det_masked[fsce_pkg::EXC_INV] & opnd_nan;
			o_resp_infinity <= det_masked[fsce_pkg::EXC_OVF] |
				det_masked[fsce_pkg::EXC_ZDV];
			o_resp_inf_sign <= i_res_sign;
			o_resp_denorm <= det_masked[fsce_pkg::EXC_UNF];
			o_resp_continue <= det_masked[fsce_pkg::EXC_PRE] |
				det_masked[fsce_pkg::EXC_DEN];
			o_exc_fault <= |(i_exc_detect & ~mask_now);
		end
	end
endmodule // fsce_top

// [test/fsce_top_assertions.sv]
`timescale 1ns/1ps
// watches the top ports only; attached by bind from the testbench
module fsce_top_assertions (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd_code,
	input wire logic i_exec_start,
	input wire logic i_exec_done,
	input wire logic [31:0] i_esc_addr,
	input wire logic [3:0] i_prefix_len,
	input wire logic i_prot_mode,
	input wire logic [1:0] i_stack_op,
	input wire logic [2:0] i_reg_rel,
	input wire logic [5:0] i_exc_detect,
	input wire logic i_res_sign,
	input wire logic o_rd_valid,
	input wire logic [2:0] o_reg_index,
	input wire logic o_busy,
	input wire logic o_error,
	input wire logic [15:0] o_status,
	input wire logic [15:0] o_control,
	input wire logic [31:0] o_instr_ptr,
	input wire logic [10:0] o_opcode,
	input wire logic o_resp_infinity,
	input wire logic o_resp_inf_sign,
	input wire logic o_exc_fault
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// busy state and its status bit
	a_busy_start: assert property (i_exec_start && !i_cmd_valid |=> o_busy)
		else $error("busy not raised after start");
	a_busy_bit: assert property (o_status[15] == o_busy)
		else $error("status busy bit differs from busy output");
	// store codes 1 to 4 answer next cycle and leave busy alone
	a_store_answer: assert property (i_cmd_valid && i_cmd_code inside {[4'h1:4'h4]} |=>
		o_rd_valid && (o_busy == $past(o_busy) || $past(i_exec_start) || $past(i_exec_done)))
		else $error("store late or disturbed busy");
	// summary is exactly unmasked flags, pin mirrors it
	a_summary_exact: assert property (o_error == o_status[7] &&
		o_status[7] == |(o_status[5:0] & ~o_control[5:0]))
		else $error("error summary inconsistent");
	// without commands flags only accumulate
	a_flags_sticky: assert property (!i_cmd_valid |=>
		o_status[5:0] == ($past(o_status[5:0]) | $past(i_exc_detect)))
		else $error("exception flags not sticky");
	a_unmasked_fault: assert property ((i_exc_detect & ~o_control[5:0]) != 6'h00 && !i_cmd_valid
		|=> o_exc_fault)
		else $error("unmasked exception gave no fault");
	a_masked_ovf: assert property (i_exc_detect[fsce_pkg::EXC_OVF] &&
		o_control[fsce_pkg::EXC_OVF] && !i_cmd_valid
		|=> o_resp_infinity && o_resp_inf_sign == $past(i_res_sign))
		else $error("masked overflow gave no signed infinity");
	// stack pointer movement and relative indexing wrap in three bits
	a_push_top: assert property (i_stack_op == fsce_pkg::FSCE_STK_PUSH && !i_cmd_valid |=>
		o_status[14:12] == $past(o_status[14:12]) - 3'h1 && o_reg_index == o_status[14:12])
		else $error("push did not decrement top");
	a_rel_index: assert property (i_stack_op == fsce_pkg::FSCE_STK_NONE && !i_cmd_valid |=>
		o_reg_index == o_status[14:12] + $past(i_reg_rel))
		else $error("relative register index wrong");
	// protected capture: prefix start, no opcode, two cycles to the outputs
	a_ptr_capture: assert property (i_cmd_valid && i_prot_mode &&
		i_cmd_code == fsce_pkg::FSCE_CMD_ESC_EXEC |-> ##2
		o_instr_ptr == $past(i_esc_addr, 2) - {28'h0000000, $past(i_prefix_len, 2)} &&
		o_opcode == 11'h000)
		else $error("captured pointer wrong");
endmodule // fsce_top_assertions

// [test/fsce_host_model.sv]
`timescale 1ns/1ps
// host side: issues escape commands as one-cycle strobes
module fsce_host_model (
	input wire logic i_clk,
	input wire logic i_rd_valid,
	input wire logic [15:0] i_rd_data,
	output logic o_cmd_valid,
	output logic [3:0] o_cmd_code,
	output logic [2:0] o_cmd_word,
	output logic [15:0] o_cmd_data
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code = 4'h0;
		o_cmd_word = 3'h0;
		o_cmd_data = 16'h0000;
	end
	// data is inverted after the strobe so stale values never pass
	task automatic send(input logic [3:0] c, input logic [2:0] w, input logic [15:0] d);
		@(posedge i_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_code <= c;
		o_cmd_word <= w;
		o_cmd_data <= d;
		@(posedge i_clk);
		o_cmd_valid <= 1'b0;
		o_cmd_data <= ~d;
		#1;
	endtask
	// a missing answer comes back unknown
	task automatic fetch(input logic [3:0] c, input logic [2:0] w, output logic [15:0] q);
		send(c, w, 16'h0000);
		q = i_rd_valid ? i_rd_data : 16'hXXXX;
	endtask
endmodule // fsce_host_model

// [test/fsce_top_test.sv]
`timescale 1ns/1ps
module fsce_top_test;
	logic i_clk = 1'b0;
	logic i_sys_rst, i_cmd_valid, i_exec_start, i_exec_done, i_oper_valid, i_prot_mode;
	logic i_res_sign, i_rem_complete, i_opnd_sign, i_opnd_empty, o_rd_valid, o_busy, o_error;
	logic o_exc_fault, o_resp_nan_default, o_resp_nan_prop, o_resp_infinity, o_resp_inf_sign;
	logic o_resp_denorm, o_resp_continue;
	logic [3:0] i_cmd_code, i_prefix_len, i_cc_value;
	logic [2:0] i_cmd_word, i_reg_rel, i_cc_kind, i_rem_quot, o_reg_index;
	logic [1:0] i_stack_op, i_cmp_result;
	logic [5:0] i_exc_detect;
	logic [10:0] i_opcode, o_opcode;
	logic [14:0] i_opnd_exp;
	logic [15:0] i_cmd_data, o_rd_data, o_status, o_control, q;
	logic [31:0] i_esc_addr, i_oper_addr, o_instr_ptr, o_oper_ptr;
	logic [63:0] i_opnd_sig;
	int err_count = 0;
	int n_compared = 0;
	always #5 i_clk = ~i_clk;
	fsce_top dut_u (.i_clk, .i_sys_rst, .i_cmd_valid, .i_cmd_code, .i_cmd_word, .i_cmd_data,
		.o_rd_valid, .o_rd_data, .i_exec_start, .i_exec_done, .i_esc_addr, .i_prefix_len,
		.i_oper_valid, .i_oper_addr, .i_opcode, .i_prot_mode, .i_stack_op, .i_reg_rel,
		.i_exc_detect, .i_res_sign, .i_cc_kind, .i_cmp_result, .i_rem_complete, .i_rem_quot,
		.i_cc_value, .i_opnd_sign, .i_opnd_exp, .i_opnd_sig, .i_opnd_empty, .o_reg_index,
		.o_busy, .o_error, .o_status, .o_control, .o_instr_ptr, .o_oper_ptr, .o_opcode,
		.o_resp_nan_default, .o_resp_nan_prop, .o_resp_infinity, .o_resp_inf_sign,
		.o_resp_denorm, .o_resp_continue, .o_exc_fault);
	fsce_host_model host_u (.i_clk, .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
		.o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code), .o_cmd_word(i_cmd_word),
		.o_cmd_data(i_cmd_data));
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic do_reset;
		i_sys_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		#1;
	endtask
	// one edge for the pulse to be taken, then drop all pulse inputs
	task automatic step;
		@(posedge i_clk);
		i_exec_start <= 1'b0;
		i_exec_done <= 1'b0;
		i_exc_detect <= 6'h00;
		i_stack_op <= 2'h0;
		i_cc_kind <= 3'h0;
		#1;
	endtask
	// about 85 cycles of work; the limit leaves wide room
	initial begin
		#50000;
		err_count++;
		wrap_up;
	end
	initial begin : main
		int eb[6] = '{fsce_pkg::EXC_ZDV, fsce_pkg::EXC_OVF, fsce_pkg::EXC_UNF,
			fsce_pkg::EXC_PRE, fsce_pkg::EXC_INV, fsce_pkg::EXC_INV};
		logic [5:0] ev[6] = '{6'h08, 6'h0C, 6'h02, 6'h01, 6'h20, 6'h10};
		logic [3:0] cx[4] = '{4'h2, 4'h3, 4'hA, 4'hF};
		logic [3:0] xx[4] = '{4'h8, 4'h7, 4'h4, 4'h9};
		logic [14:0] xe[4] = '{15'h0000, 15'h7FFF, 15'h3FFF, 15'h0000};
		i_sys_rst = 1'b1;
		{i_exec_start, i_exec_done, i_oper_valid, i_prot_mode, i_res_sign} = 5'h00;
		{i_rem_complete, i_opnd_sign, i_opnd_empty, i_cmp_result, i_stack_op} = 7'h00;
		{i_prefix_len, i_cc_value, i_reg_rel, i_cc_kind, i_rem_quot} = 17'h00000;
		{i_exc_detect, i_opcode, i_opnd_exp, i_esc_addr, i_oper_addr} = 96'h0;
		i_opnd_sig = 64'hC000_0000_0000_0000;
		do_reset;
		check(o_control, fsce_pkg::CW_RST);
		check(o_status, fsce_pkg::SW_RST);
		// reserved control bits read back as zero; unknown code is ignored
		host_u.send(fsce_pkg::FSCE_CMD_LOAD_CTRL, 3'h0, 16'hFFFF);
		host_u.fetch(fsce_pkg::FSCE_CMD_STORE_CTRL, 3'h0, q);
		check(q, fsce_pkg::CW_USED);
		host_u.send(fsce_pkg::FSCE_CMD_LOAD_CTRL, 3'h0, 16'h1C00);
		host_u.send(4'hF, 3'h0, 16'h0000);
		check({o_rd_valid, o_control}, 17'h01C00);
		// unmasked flag, then masking it afterwards drops the summary
		@(posedge i_clk) i_exc_detect <= 6'h04;
		step;
		check({o_exc_fault, o_error, o_status}, 18'h30084);
		host_u.send(fsce_pkg::FSCE_CMD_LOAD_CTRL, 3'h0, 16'h1C04);
		check({o_error, o_status}, 17'h00004);
		host_u.send(fsce_pkg::FSCE_CMD_CLEAR_EXC, 3'h0, 16'h0000);
		check({o_error, o_status}, 17'h00000);
		host_u.send(fsce_pkg::FSCE_CMD_LOAD_CTRL, 3'h0, 16'h003F);
		// masked defaults, last entry with a nan operand
		for (int k = 0; k < 6; k++) begin
			@(posedge i_clk) begin
				i_exc_detect <= 6'h01 << eb[k];
				i_res_sign <= (k == 1);
				i_opnd_exp <= (k == 5) ? 15'h7FFF : 15'h0000;
			end
			step;
			check({o_resp_nan_default, o_resp_nan_prop, o_resp_infinity, o_resp_inf_sign,
				o_resp_denorm, o_resp_continue, o_exc_fault, o_error}, {ev[k], 2'b00});
		end
		check(o_status, 16'h003D);
		// busy window; a store while busy answers at once
		@(posedge i_clk) i_exec_start <= 1'b1;
		step;
		check(o_busy, 1'b1);
		host_u.fetch(fsce_pkg::FSCE_CMD_STORE_STATUS, 3'h0, q);
		check({q[15], o_busy}, 2'b11);
		@(posedge i_clk) i_exec_done <= 1'b1;
		step;
		check({o_status[15], o_busy}, 2'b00);
		// push wraps top to 7, relative index wraps, pop returns
		@(posedge i_clk) i_stack_op <= fsce_pkg::FSCE_STK_PUSH;
		step;
		check({o_status[14:12], o_reg_index}, 6'h3F);
		@(posedge i_clk) i_reg_rel <= 3'h5;
		step;
		check(o_reg_index, 3'h4);
		@(posedge i_clk) i_stack_op <= fsce_pkg::FSCE_STK_POP;
		step;
		check({o_status[14:12], o_reg_index}, 6'h07);
		// condition codes: arithmetic, compares keep c1, remainder, examine
		@(posedge i_clk) begin i_cc_kind <= fsce_pkg::FSCE_CC_ARITH; i_cc_value <= 4'h2; end
		step;
		check(o_status[11:8], 4'h2);
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk) begin i_cc_kind <= fsce_pkg::FSCE_CC_COMPARE; i_cmp_result <= 2'(k); end
			step;
			check(o_status[11:8], cx[k]);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk) begin
				i_cc_kind <= fsce_pkg::FSCE_CC_REMAINDER;
				i_rem_complete <= (k == 0);
				i_rem_quot <= 3'h5;
			end
			step;
			check(o_status[11:8], k ? 4'h7 : 4'h3);
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk) begin
				i_cc_kind <= fsce_pkg::FSCE_CC_EXAMINE;
				i_opnd_sign <= (k == 1);
				i_opnd_empty <= (k == 3);
				i_opnd_exp <= xe[k];
				i_opnd_sig <= (k == 0) ? 64'h0 : 64'h8000_0000_0000_0000;
			end
			step;
			check(o_status[11:8], xx[k]);
		end
		// environment status load ignores busy and summary bits; init restores defaults
		host_u.send(fsce_pkg::FSCE_CMD_LOAD_ENV, fsce_pkg::ENV_STAT, 16'hD381);
		check({o_error, o_status}, 17'h05301);
		host_u.send(fsce_pkg::FSCE_CMD_INIT, 3'h0, 16'h0000);
		check({o_control, o_status}, {fsce_pkg::CW_RST, fsce_pkg::SW_RST});
		host_u.send(fsce_pkg::FSCE_CMD_RESTORE_STATE, fsce_pkg::ENV_CTRL, 16'h0C00);
		check(o_control, 16'h0C00);
		// pointer capture, protected then real mode
		@(posedge i_clk) begin
			i_prot_mode <= 1'b1;
			i_esc_addr <= 32'h0001_2345;
			i_prefix_len <= 4'h2;
			i_oper_valid <= 1'b1;
			i_oper_addr <= 32'hABCD_0010;
			i_opcode <= 11'h5A3;
		end
		host_u.send(fsce_pkg::FSCE_CMD_ESC_EXEC, 3'h0, 16'h0000);
		@(posedge i_clk);
		#1;
		check({o_instr_ptr, o_oper_ptr, o_opcode}, {64'h0001_2343_ABCD_0010, 11'h000});
		@(posedge i_clk) begin i_prot_mode <= 1'b0; i_esc_addr <= 32'h000A_BCDE; i_prefix_len <= 4'h1; end
		host_u.send(fsce_pkg::FSCE_CMD_ESC_EXEC, 3'h0, 16'h0000);
		host_u.fetch(fsce_pkg::FSCE_CMD_STORE_ENV, fsce_pkg::ENV_IP_LO, q);
		check(q, 16'hBCDD);
		host_u.fetch(fsce_pkg::FSCE_CMD_SAVE_STATE, fsce_pkg::ENV_IP_HI, q);
		check(q, 16'hA5A3);
		// reset again in mid-run
		do_reset;
		check({o_control, o_status}, {fsce_pkg::CW_RST, fsce_pkg::SW_RST});
		wrap_up;
	end
endmodule // fsce_top_test
bind fsce_top fsce_top_assertions chk_u (.i_clk, .i_sys_rst, .i_cmd_valid, .i_cmd_code,
	.i_exec_start, .i_exec_done, .i_esc_addr, .i_prefix_len, .i_prot_mode, .i_stack_op,
	.i_reg_rel, .i_exc_detect, .i_res_sign, .o_rd_valid, .o_reg_index, .o_busy, .o_error,
	.o_status, .o_control, .o_instr_ptr, .o_opcode, .o_resp_infinity, .o_resp_inf_sign,
	.o_exc_fault);
